// ---- hw/cct_defines.svh ----
// register indices, field positions, reset values and timing counts of the capture/compare timer
`ifndef CCT_DEFINES_SVH
`define CCT_DEFINES_SVH

// ==========================================================================
// register indices (byte address = index * 4)
`define CCT_IDX_FUNC 8'h80
`define CCT_IDX_FORCE 8'h81
`define CCT_IDX_MASK7 8'h82
`define CCT_IDX_DATA7 8'h83
`define CCT_IDX_CNT 8'h84
`define CCT_IDX_SYS 8'h86
`define CCT_IDX_ACTION 8'h88
`define CCT_IDX_EDGE 8'h8a
`define CCT_IDX_CHMASK 8'h8c
`define CCT_IDX_OVMASK 8'h8d
`define CCT_IDX_CHFLAG 8'h8e
`define CCT_IDX_OVFLAG 8'h8f
`define CCT_IDX_CAP 8'h90
`define CCT_IDX_HOLD 8'h98
`define CCT_IDX_PDATA 8'h9c
`define CCT_IDX_PDIR 8'h9d
`define CCT_IDX_ACC 8'ha0
`define CCT_IDX_ACCHOLD 8'ha4
`define CCT_IDX_ACCFLAG 8'ha8
`define CCT_IDX_MODCNT 8'hb0
`define CCT_IDX_MODCTL 8'hb1
`define CCT_IDX_MODFLAG 8'hb2

// ==========================================================================
// field positions
`define CCT_SYS_RUN 7
`define CCT_SYS_WAIT_STOP 6
`define CCT_SYS_DEBUG_STOP 5
`define CCT_SYS_FAST_CLEAR 4
`define CCT_OV_BIT 7
`define CCT_MOD_ENABLE 0
`define CCT_MOD_PERIODIC 1
`define CCT_MOD_FORCE_LATCH 2
`define CCT_MOD_LATCH_MODE 3
`define CCT_MOD_SATURATE 4
`define CCT_MOD_PAIR_B 5
`define CCT_MOD_PAIR_A 6
`define CCT_MOD_IRQ_EN 7
`define CCT_ACCF_A_INPUT 0
`define CCT_ACCF_A_OVF 1
`define CCT_ACCF_B_OVF 2

// ==========================================================================
// reset values and timing
`define CCT_RST8 8'h00
`define CCT_RST16 16'h0000
`define CCT_FORCE_READ 8'h00
`define CCT_PACC_DIV 64

`endif

// ---- hw/cct_pkg.sv ----
// types shared by the capture/compare timer
package cct_pkg;

    // ======================================================================
    // bus carriers
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [9:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // ======================================================================
    // complete module state
    typedef struct packed {
        logic [10:0] s1;
        logic [10:0] s2;
        logic [7:0] pin_prev;
        logic [7:0] func_sel;
        logic [7:0] mask7;
        logic [7:0] data7;
        logic [7:0] sys_ctl;
        logic [7:0] ov_mask;
        logic [7:0] ch_mask;
        logic [7:0] ch_flag;
        logic ov_flag;
        logic [7:0] port_data;
        logic [7:0] port_dir;
        logic [7:0] oc_out;
        logic [7:0] pin_out;
        logic [7:0] pin_oe;
        logic [15:0] counter;
        logic [15:0] action;
        logic [15:0] edge_cfg;
        logic [7:0][15:0] cap;
        logic [3:0][15:0] hold;
        logic [3:0][7:0] acc;
        logic [3:0][7:0] acc_hold;
        logic [2:0] acc_flag;
        logic [5:0] pres;
        logic [15:0] mod_cnt;
        logic [15:0] mod_load;
        logic [7:0] mod_ctl;
        logic mod_flag;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } cct_state_t;

endpackage : cct_pkg

// ---- hw/capture_compare_timer_core.sv ----
// capture/compare timer core with pulse accumulators, modulus counter and wishbone slave
//
// Overview of operation
// - queue mode: reading a capture holding register copies its accumulator to accumulator holding
// - four 8-bit edge accumulators on channels 0-3, each with its own holding register
// - saturate bit makes accumulators stop at maximum instead of wrapping
// - each accumulator pair can run as one 16-bit accumulator
// - latch mode: modulus zero, zero write or force latch copies and clears accumulators
// - queue mode: holding register read also clears the associated accumulator
// - modulus down-counter gives periodic events and latches, repeating or once
// - an enabled compare function drives its pin regardless of direction bit
// - function select bit: 0 is input capture, 1 is output compare
// - force bits fire compare action without flag; force register reads zero
// - channel-7 mask on a compare channel makes the pin an output
// - channel-7 compare copies masked channel-7 data bits to port outputs
// - a set channel-7 mask blocks the channel's own output action
// - simultaneous compares on a masked pin: channel-7 data bit wins
// - main counter is 16-bit up counter, writable only in special mode
// - clearing run bit halts counter and the divide-by-64 modulus counter tick
// - wait stop halts timer, accumulators and modulus counter in wait mode
// - debug stop halts timer and modulus counter, accumulators keep counting
// - fast flag clear lets register accesses clear their associated flags
// - two-bit output action: disconnect, toggle, clear, set; nonzero drives pin
// - two-bit edge control: off, rising, falling, either
// - channel and overflow enables gate flags onto the interrupt request
// - flags clear by writing one, writing zero leaves them unchanged
// - overflow flag sets when counter wraps from maximum to zero
`timescale 1ns/100ps
`default_nettype none
`include "cct_defines.svh"

module capture_compare_timer_core #(
    parameter int unsigned PACC_DIV = `CCT_PACC_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire cct_pkg::wb_req_t i_wb,
    output var cct_pkg::wb_rsp_t o_wb,
    input wire logic [7:0] i_port_pin,
    output logic [7:0] o_port_out,
    output logic [7:0] o_port_oe,
    input wire logic i_wait_mode,
    input wire logic i_debug_mode,
    input wire logic i_special_mode_select_n,
    output logic o_timer_irq
);
    import cct_pkg::*;

    localparam logic [5:0] PRES_MAX = 6'(PACC_DIV - 1);

    cct_state_t q;
    cct_state_t d;

    logic [7:0] pins;
    logic in_wait;
    logic in_debug;
    logic special;
    logic timer_on;
    logic acc_on;
    logic mod_on;
    logic tick64;
    logic go;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [7:0] sub;
    logic [15:0] wval;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] edge_hit;
    logic [7:0] cmp_hit;
    logic [7:0] cap_hit;
    logic [7:0] force_now;
    logic [7:0] ch_clr;
    logic ov_clr;
    logic ov_set;
    logic [2:0] accf_clr;
    logic [2:0] accf_set;
    logic modf_clr;
    logic mod_zero;
    logic mod_write0;
    logic force_latch;
    logic latch_mode;
    logic latch_now;
    logic [3:0] queue_xfer;
    logic [1:0] act;
    logic paired;
    logic sat;
    logic [15:0] wide;
    logic [7:0] drive_fn;
    logic [31:0] rdata;

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
        begin
            r[7:0] = dat[7:0];
        end
        if (sel[1])
        begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction : merge16

    // ======================================================================
    // next state
    always_comb
    begin
        d = q;
        // pins and mode inputs pass two flip-flops; s1 feeds only s2
        d.s1 = {i_special_mode_select_n, i_debug_mode, i_wait_mode, i_port_pin};
        d.s2 = q.s1;
        pins = q.s2[7:0];
        in_wait = q.s2[8];
        in_debug = q.s2[9];
        special = !q.s2[10];
        d.pin_prev = pins;

        timer_on = q.sys_ctl[`CCT_SYS_RUN]
            & !(q.sys_ctl[`CCT_SYS_WAIT_STOP] & in_wait)
            & !(q.sys_ctl[`CCT_SYS_DEBUG_STOP] & in_debug);
        acc_on = !(q.sys_ctl[`CCT_SYS_WAIT_STOP] & in_wait);
        mod_on = timer_on & q.mod_ctl[`CCT_MOD_ENABLE];
        tick64 = timer_on && (q.pres == PRES_MAX);
        if (timer_on)
        begin
            d.pres = (q.pres == PRES_MAX) ? 6'h00 : q.pres + 6'h01;
        end
        latch_mode = q.mod_ctl[`CCT_MOD_LATCH_MODE];
        sat = q.mod_ctl[`CCT_MOD_SATURATE];

        // ==================================================================
        // bus decode; every access is answered one edge later
        go = i_wb.cyc & i_wb.stb & !q.ack;
        wr = go & i_wb.we;
        rd = go & !i_wb.we;
        idx = i_wb.adr[9:2];
        wval = merge16(16'h0000, i_wb.dat, i_wb.sel);
        d.ack = go;
        ch_clr = 8'h00;
        ov_clr = 1'b0;
        accf_clr = 3'h0;
        modf_clr = 1'b0;
        mod_write0 = 1'b0;
        force_latch = 1'b0;
        force_now = 8'h00;
        queue_xfer = 4'h0;
        rdata = 32'h0000_0000;
        sub = 8'h00;

        if (go)
        begin
            case (idx)
                `CCT_IDX_FUNC: rdata = {24'h0, q.func_sel};
                `CCT_IDX_FORCE: rdata = {24'h0, `CCT_FORCE_READ};
                `CCT_IDX_MASK7: rdata = {24'h0, q.mask7};
                `CCT_IDX_DATA7: rdata = {24'h0, q.data7};
                `CCT_IDX_CNT: rdata = {16'h0, q.counter};
                `CCT_IDX_SYS: rdata = {24'h0, q.sys_ctl};
                `CCT_IDX_ACTION: rdata = {16'h0, q.action};
                `CCT_IDX_EDGE: rdata = {16'h0, q.edge_cfg};
                `CCT_IDX_CHMASK: rdata = {24'h0, q.ch_mask};
                `CCT_IDX_OVMASK: rdata = {24'h0, q.ov_mask};
                `CCT_IDX_CHFLAG: rdata = {24'h0, q.ch_flag};
                `CCT_IDX_OVFLAG: rdata = {24'h0, q.ov_flag, 7'h00};
                `CCT_IDX_PDATA: rdata = {24'h0, (pins & ~q.pin_oe) | (q.pin_out & q.pin_oe)};
                `CCT_IDX_PDIR: rdata = {24'h0, q.port_dir};
                `CCT_IDX_ACCFLAG: rdata = {29'h0, q.acc_flag};
                `CCT_IDX_MODCNT: rdata = {16'h0, q.mod_cnt};
                `CCT_IDX_MODCTL: rdata = {24'h0, q.mod_ctl & 8'hfb};
                `CCT_IDX_MODFLAG: rdata = {31'h0, q.mod_flag};
                default: rdata = 32'h0000_0000;
            endcase
            if (idx == `CCT_IDX_CNT && q.sys_ctl[`CCT_SYS_FAST_CLEAR])
            begin
                ov_clr = 1'b1;
            end
            if (idx == `CCT_IDX_MODCNT && q.sys_ctl[`CCT_SYS_FAST_CLEAR])
            begin
                modf_clr = 1'b1;
            end
            sub = idx - `CCT_IDX_CAP;
            if (sub < 8'h08)
            begin
                rdata = {16'h0, q.cap[sub[2:0]]};
                if (q.sys_ctl[`CCT_SYS_FAST_CLEAR] && (q.func_sel[sub[2:0]] == wr))
                begin
                    ch_clr[sub[2:0]] = 1'b1;
                end
                if (wr)
                begin
                    d.cap[sub[2:0]] = merge16(q.cap[sub[2:0]], i_wb.dat, i_wb.sel);
                end
            end
            sub = idx - `CCT_IDX_HOLD;
            if (sub < 8'h04)
            begin
                rdata = {16'h0, q.hold[sub[1:0]]};
                queue_xfer[sub[1:0]] = rd & !latch_mode;
            end
            sub = idx - `CCT_IDX_ACC;
            if (sub < 8'h04)
            begin
                rdata = {24'h0, q.acc[sub[1:0]]};
                if (q.sys_ctl[`CCT_SYS_FAST_CLEAR])
                begin
                    accf_clr = sub[1] ? 3'b011 : 3'b100;
                end
                if (wr && i_wb.sel[0])
                begin
                    d.acc[sub[1:0]] = i_wb.dat[7:0];
                end
            end
            sub = idx - `CCT_IDX_ACCHOLD;
            if (sub < 8'h04)
            begin
                rdata = {24'h0, q.acc_hold[sub[1:0]]};
            end
        end
        d.rdata = rdata;

        if (wr && i_wb.sel[0])
        begin
            case (idx)
                `CCT_IDX_FUNC: d.func_sel = i_wb.dat[7:0];
                `CCT_IDX_FORCE: force_now = i_wb.dat[7:0];
                `CCT_IDX_MASK7: d.mask7 = i_wb.dat[7:0];
                `CCT_IDX_DATA7: d.data7 = i_wb.dat[7:0];
                `CCT_IDX_SYS: d.sys_ctl = i_wb.dat[7:0] & 8'hf0;
                `CCT_IDX_CHMASK: d.ch_mask = i_wb.dat[7:0];
                `CCT_IDX_OVMASK: d.ov_mask = i_wb.dat[7:0];
                `CCT_IDX_CHFLAG: ch_clr = ch_clr | i_wb.dat[7:0];
                `CCT_IDX_OVFLAG: ov_clr = ov_clr | i_wb.dat[`CCT_OV_BIT];
                `CCT_IDX_PDATA: d.port_data = i_wb.dat[7:0];
                `CCT_IDX_PDIR: d.port_dir = i_wb.dat[7:0];
                `CCT_IDX_ACCFLAG: accf_clr = accf_clr | i_wb.dat[2:0];
                `CCT_IDX_MODFLAG: modf_clr = modf_clr | i_wb.dat[0];
                `CCT_IDX_MODCTL:
                begin
                    d.mod_ctl = i_wb.dat[7:0] & 8'hfb;
                    force_latch = i_wb.dat[`CCT_MOD_FORCE_LATCH];
                end
                default: d.func_sel = q.func_sel;
            endcase
        end
        if (wr)
        begin
            case (idx)
                `CCT_IDX_ACTION: d.action = merge16(q.action, i_wb.dat, i_wb.sel);
                `CCT_IDX_EDGE: d.edge_cfg = merge16(q.edge_cfg, i_wb.dat, i_wb.sel);
                default: d.action = q.action;
            endcase
        end

        // ==================================================================
        // main counter; a bus write in special mode wins over the increment
        ov_set = 1'b0;
        if (timer_on)
        begin
            d.counter = q.counter + 16'h0001;
            ov_set = (q.counter == 16'hffff);
        end
        if (wr && idx == `CCT_IDX_CNT && special)
        begin
            d.counter = merge16(q.counter, i_wb.dat, i_wb.sel);
        end

        // ==================================================================
        // edge detection, capture and compare
        rise = pins & ~q.pin_prev;
        fall = ~pins & q.pin_prev;
        cmp_hit = 8'h00;
        cap_hit = 8'h00;
        for (int n = 0; n < 8; n++)
        begin
            case (q.edge_cfg[2 * n +: 2])
                2'b01: edge_hit[n] = rise[n];
                2'b10: edge_hit[n] = fall[n];
                2'b11: edge_hit[n] = rise[n] | fall[n];
                default: edge_hit[n] = 1'b0;
            endcase
            if (q.func_sel[n])
            begin
                cmp_hit[n] = timer_on && (q.counter == q.cap[n]);
            end
            else if (edge_hit[n])
            begin
                cap_hit[n] = 1'b1;
                d.cap[n] = q.counter;
                if (n < 4 && !latch_mode)
                begin
                    d.hold[n] = q.cap[n];
                end
            end
        end

        // output actions first, channel-7 data overrides masked pins after
        for (int n = 0; n < 8; n++)
        begin
            act = q.action[2 * n +: 2];
            if ((cmp_hit[n] | force_now[n]) && q.func_sel[n] && !q.mask7[n])
            begin
                case (act)
                    2'b01: d.oc_out[n] = !q.oc_out[n];
                    2'b10: d.oc_out[n] = 1'b0;
                    2'b11: d.oc_out[n] = 1'b1;
                    default: d.oc_out[n] = q.oc_out[n];
                endcase
            end
            if ((cmp_hit[7] | force_now[7]) && q.mask7[n])
            begin
                d.oc_out[n] = q.data7[n];
            end
            drive_fn[n] = d.func_sel[n] & ((d.action[2 * n +: 2] != 2'b00) | d.mask7[n]);
        end
        // timer function overrides the direction bit, which itself is left alone
        d.pin_oe = d.port_dir | drive_fn;
        d.pin_out = (drive_fn & d.oc_out) | (~drive_fn & d.port_data);

        // ==================================================================
        // pulse accumulators, pair p is bytes 2p+1:2p
        accf_set = 3'h0;
        wide = 16'h0000;
        for (int p = 0; p < 2; p++)
        begin
            paired = (p == 0) ? q.mod_ctl[`CCT_MOD_PAIR_B] : q.mod_ctl[`CCT_MOD_PAIR_A];
            if (paired)
            begin
                wide = {d.acc[2 * p + 1], d.acc[2 * p]};
                if (acc_on && edge_hit[2 * p] && !(sat && wide == 16'hffff))
                begin
                    {d.acc[2 * p + 1], d.acc[2 * p]} = wide + 16'h0001;
                    accf_set[p == 0 ? 2 : 1] = (wide == 16'hffff);
                    accf_set[0] = accf_set[0] | (p == 1);
                end
            end
            else
            begin
                for (int k = 2 * p; k < 2 * p + 2; k++)
                begin
                    if (acc_on && edge_hit[k] && !(sat && d.acc[k] == 8'hff))
                    begin
                        d.acc[k] = d.acc[k] + 8'h01;
                        if (k == 1 || k == 3)
                        begin
                            accf_set[k == 1 ? 2 : 1] = (q.acc[k] == 8'hff);
                        end
                        accf_set[0] = accf_set[0] | (k == 2);
                    end
                end
            end
        end

        // ==================================================================
        // modulus down-counter; in one-shot mode it rests at zero, so it latches once
        mod_zero = 1'b0;
        if (wr && idx == `CCT_IDX_MODCNT)
        begin
            d.mod_load = merge16(q.mod_load, i_wb.dat, i_wb.sel);
            d.mod_cnt = merge16(q.mod_cnt, i_wb.dat, i_wb.sel);
            mod_write0 = (wval == 16'h0000);
        end
        else if (mod_on && tick64 && q.mod_cnt != 16'h0000)
        begin
            d.mod_cnt = q.mod_cnt - 16'h0001;
            if (q.mod_cnt == 16'h0001)
            begin
                mod_zero = 1'b1;
                if (q.mod_ctl[`CCT_MOD_PERIODIC])
                begin
                    d.mod_cnt = q.mod_load;
                end
            end
        end

        // latching clears the accumulator after this cycle's count
        latch_now = latch_mode & (mod_zero | mod_write0 | force_latch);
        for (int k = 0; k < 4; k++)
        begin
            if (latch_now)
            begin
                d.hold[k] = d.cap[k];
            end
            if (latch_now || queue_xfer[k])
            begin
                d.acc_hold[k] = d.acc[k];
                d.acc[k] = 8'h00;
            end
        end

        // ==================================================================
        // flags: a set in the same cycle as a clear wins
        d.ch_flag = (q.ch_flag & ~ch_clr) | cmp_hit | cap_hit;
        d.ov_flag = (q.ov_flag & !ov_clr) | ov_set;
        d.acc_flag = (q.acc_flag & ~accf_clr) | accf_set;
        d.mod_flag = (q.mod_flag & !modf_clr) | mod_zero;
        d.irq = (|(d.ch_flag & d.ch_mask)) | (d.ov_flag & d.ov_mask[`CCT_OV_BIT])
            | (d.mod_flag & d.mod_ctl[`CCT_MOD_IRQ_EN]);
    end

    // ======================================================================
    // state register
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            q <= '0;
            // the special mode strap is active low; reset it idle or the counter opens up
            q.s1[10] <= 1'b1;
            q.s2[10] <= 1'b1;
            q.counter <= `CCT_RST16;
            q.sys_ctl <= `CCT_RST8;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_wb.ack = q.ack;
    assign o_wb.dat = q.rdata;
    assign o_port_out = q.pin_out;
    assign o_port_oe = q.pin_oe;
    assign o_timer_irq = q.irq;

endmodule : capture_compare_timer_core

`default_nettype wire

// ---- verif/cct_checker_asserts.sv ----
// checker of bus and port relations of the timer core
`timescale 1ns/100ps
`default_nettype none
module cct_checker #(
    parameter int unsigned PACC_DIV = 64
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire cct_pkg::wb_req_t i_wb,
    input wire cct_pkg::wb_rsp_t o_wb,
    input wire logic [7:0] o_port_out,
    input wire logic [7:0] o_port_oe,
    input wire logic o_timer_irq
);
    import cct_pkg::*;
    // ==================================================================
    // helpers
    logic [7:0] idx;
    logic rd_ack;
    assign idx = i_wb.adr[9:2];
    assign rd_ack = o_wb.ack && !i_wb.we;
    // ==================================================================
    // assertions
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    a_ack_pulse: assert property (o_wb.ack |=> !o_wb.ack)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (i_wb.cyc && i_wb.stb && !o_wb.ack |=> o_wb.ack)
        else $error("request not answered");
    a_ack_cause: assert property (o_wb.ack |-> $past(i_wb.cyc && i_wb.stb))
        else $error("ack without request");
    a_idle_data: assert property (!o_wb.ack |-> o_wb.dat == 32'h0)
        else $error("read data outside ack");
    a_force_zero: assert property (rd_ack && idx == 8'h81 |-> o_wb.dat == 32'h0)
        else $error("force register read not zero");
    a_latch_zero: assert property (rd_ack && idx == 8'hb1 |-> !o_wb.dat[2])
        else $error("force latch bit read as one");
    // enables come from registers only, so a change needs a write just before
    a_oe_cause: assert property ($changed(o_port_oe) |->
        (o_wb.ack && i_wb.we) || $past(o_wb.ack && i_wb.we))
        else $error("output enable changed without write");
    a_reset_quiet: assert property ($fell(i_reset) |->
        !o_timer_irq && o_port_oe == 8'h00 && o_port_out == 8'h00)
        else $error("outputs active after reset");
    c_write: cover property (o_wb.ack && i_wb.we);
    c_irq: cover property ($rose(o_timer_irq));
    c_oe: cover property ($rose(o_port_oe[1]));
endmodule : cct_checker

bind capture_compare_timer_core cct_checker #(.PACC_DIV(PACC_DIV)) chk_u (.i_sys_clk,
    .i_reset, .i_wb, .o_wb, .o_port_out, .o_port_oe, .o_timer_irq);
`default_nettype wire

// ---- verif/pin_model.sv ----
// model of the pins facing the timer port
`timescale 1ns/100ps
`default_nettype none
module pin_model (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_port_out,
    input wire logic [7:0] i_port_oe,
    output var logic [7:0] o_pins
);
    // ==================================================================
    // pin levels
    logic [7:0] lvl_q = 8'h00;
    // a driven pin reads back the timer's level, else the outside level
    assign o_pins = (i_port_oe & i_port_out) | (~i_port_oe & lvl_q);
    // four cycles a level so the synchroniser never misses an edge
    task automatic pulse(input int ch, input int n);
        repeat (n)
        begin
            repeat (4) @(posedge i_sys_clk);
            lvl_q[ch] <= 1'b1;
            repeat (4) @(posedge i_sys_clk);
            lvl_q[ch] <= 1'b0;
        end
        repeat (6) @(posedge i_sys_clk);
    endtask : pulse
endmodule : pin_model
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench of the timer core
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cct_pkg::*;
    logic clk;
    logic rst = 1'b1;
    logic smode_n = 1'b1;
    logic wt = 1'b0;
    logic dbg = 1'b0;
    wb_req_t wb = '0;
    wb_rsp_t rsp;
    logic [7:0] pins;
    logic [7:0] pout;
    logic [7:0] poe;
    logic irq;
    logic [31:0] rv;
    logic [7:0] cnt [4] = '{8'h00, 8'h02, 8'h02, 8'h04};
    int fails = 0;
    int check_count = 0;
    // ==================================================================
    // design and pins
    capture_compare_timer_core #(.PACC_DIV(4)) dut_u (.i_sys_clk(clk), .i_reset(rst), .i_wb(wb),
        .o_wb(rsp), .i_port_pin(pins), .o_port_out(pout), .o_port_oe(poe), .i_wait_mode(wt),
        .i_debug_mode(dbg), .i_special_mode_select_n(smode_n), .o_timer_irq(irq));
    pin_model pin_u (.i_sys_clk(clk), .i_port_out(pout), .i_port_oe(poe), .o_pins(pins));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ==================================================================
    // tasks
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb <= {2'b11, w, 4'hf, a, 2'b00, d};
        @(posedge clk);
        while (rsp.ack !== 1'b1) @(posedge clk);
        rv = rsp.dat;
        wb <= '0;
        @(posedge clk);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rv, e);
    endtask : rc
    task automatic close_out;
        if (fails == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    // ==================================================================
    // tests
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wr(8'h84, 32'h1234);
        rc(8'h84, 32'h0);
        smode_n <= 1'b0;
        repeat (5) @(posedge clk);
        wr(8'h84, 32'hfff0);
        repeat (10) @(posedge clk);
        rc(8'h84, 32'hfff0);
        wr(8'h86, 32'h80);
        repeat (20) @(posedge clk);
        wr(8'h86, 32'h0);
        rc(8'h8f, 32'h80);
        wr(8'h8d, 32'h80);
        chk(32'(irq), 32'h1);
        wr(8'h86, 32'h10);
        // run bit stood for 23 edges, so fff0 wrapped to 0007
        rc(8'h84, 32'h0007);
        rc(8'h8f, 32'h0);
        chk(32'(irq), 32'h0);
        wr(8'h80, 32'h01);
        rc(8'h80, 32'h01);
        chk(32'(poe), 32'h0);
        for (int c = 1; c < 4; c++)
        begin
            wr(8'h88, 32'(c));
            wr(8'h81, 32'h01);
            chk(32'(poe), 32'h1);
            chk(32'(pout), (c == 2) ? 32'h0 : 32'h1);
        end
        rc(8'h81, 32'h0);
        rc(8'h8e, 32'h0);
        wr(8'h88, 32'h0);
        wr(8'h80, 32'h82);
        wr(8'h82, 32'h02);
        chk(32'(poe), 32'h02);
        rc(8'h9d, 32'h0);
        wr(8'h88, 32'h0c);
        wr(8'h81, 32'h02);
        chk(32'(pout), 32'h0);
        wr(8'h83, 32'h02);
        wr(8'h81, 32'h80);
        chk(32'(pout), 32'h02);
        wr(8'h83, 32'h0);
        wr(8'h81, 32'h82);
        chk(32'(pout), 32'h0);
        wr(8'h80, 32'h0);
        wr(8'h82, 32'h0);
        for (int c = 0; c < 4; c++)
        begin
            wr(8'h8a, 32'(c));
            wr(8'ha0, 32'h0);
            pin_u.pulse(0, 2);
            rc(8'ha0, 32'(cnt[c]));
        end
        wr(8'hb1, 32'h08);
        wr(8'hb1, 32'h0c);
        rc(8'ha4, 32'h04);
        rc(8'ha0, 32'h0);
        wr(8'hb1, 32'h0);
        pin_u.pulse(0, 1);
        bus(1'b0, 8'h98, 32'h0);
        rc(8'ha4, 32'h02);
        rc(8'ha0, 32'h0);
        wr(8'hb1, 32'h10);
        wr(8'ha0, 32'hfe);
        pin_u.pulse(0, 2);
        rc(8'ha0, 32'hff);
        wr(8'hb1, 32'h20);
        wr(8'ha0, 32'hff);
        pin_u.pulse(0, 1);
        rc(8'ha1, 32'h01);
        wr(8'h8c, 32'h01);
        chk(32'(irq), 32'h1);
        wr(8'h8e, 32'h0);
        rc(8'h8e, 32'h01);
        wr(8'h8e, 32'h01);
        rc(8'h8e, 32'h0);
        chk(32'(irq), 32'h0);
        wt <= 1'b1;
        dbg <= 1'b1;
        rc(8'hb1, 32'h20);
        wr(8'h86, 32'hf0);
        repeat (5) @(posedge clk);
        rc(8'h84, 32'h0007);
        wt <= 1'b0;
        wr(8'ha0, 32'h0);
        pin_u.pulse(0, 1);
        rc(8'ha0, 32'h02);
        rc(8'h84, 32'h0007);
        wt <= 1'b1;
        pin_u.pulse(0, 1);
        rc(8'ha0, 32'h02);
        wt <= 1'b0;
        dbg <= 1'b0;
        wr(8'hb0, 32'h02);
        wr(8'hb1, 32'h01);
        repeat (20) @(posedge clk);
        rc(8'hb2, 32'h01);
        rc(8'hb0, 32'h0);
        close_out();
    end
    // the tests need a few hundred cycles; this leaves wide margin
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule : tb
`default_nettype wire
